/* File: logic/ascr_responder.sv */
/*
  Line-oriented ASCII command responder: buffers a received line, parses
  the command and identifier, updates the calibration mode and sends a reply.
  Assumes rx bytes arrive one per valid pulse, and the gas value arrives
  already formatted as decimal ASCII in the selected units, space padded.
*/
`timescale 1ns/1ps
module ascr_responder
  import ascr_pkg::*;
#(
  parameter int LINE_LEN = ASCR_LINE_LEN
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ascr_byte_t rx_i,
  input wire logic tx_ready_i,
  input wire logic [ASCR_ID_LEN*8-1:0] serial_id_i,
  input wire logic [ASCR_GAS_LEN*8-1:0] gas_text_i,
  input wire ascr_cond_t cond_i,
  input wire logic cal_allowed_i,
  input wire logic [1:0] light_i,
  input wire logic [1:0] proto_sel_i,
  input wire logic log_wr_i,
  input wire logic [16:0] log_period_i,
  input wire logic dil_wr_i,
  input wire logic [15:0] dil_ratio_i,
  input wire logic comp_wr_i,
  input wire logic comp_sel_i,
  output ascr_byte_t tx_o,
  output ascr_mode_t mode_o,
  output logic reboot_o,
  output logic [1:0] light_o,
  output logic [1:0] proto_o,
  output logic [16:0] log_period_o,
  output logic log_reject_o,
  output logic [15:0] dil_ratio_o,
  output logic comp_sel_o
);
  // Buffer must hold WORD,ID and fit the 7-bit length counter
  if (LINE_LEN < ASCR_WORD_LEN + 1 + ASCR_ID_LEN || LINE_LEN > 64) begin : g_bad_len
    $error("LINE_LEN out of range");
  end

  // Receive, parse and send phases
  typedef enum logic [1:0] {
    ASCR_ST_RX = 2'b00,
    ASCR_ST_PARSE = 2'b01,
    ASCR_ST_SEND = 2'b10
  } ascr_state_t;

  // Whole state of the responder in one register
  typedef struct packed {
    ascr_state_t st;
    logic [LINE_LEN*8-1:0] line;
    logic [6:0] len;
    logic overflow;
    logic [ASCR_REPLY_LEN*8-1:0] reply;
    logic [4:0] rlen;
    logic [4:0] ridx;
    logic reboot_pend;
    ascr_byte_t tx;
    ascr_mode_t mode;
    logic reboot;
    logic [1:0] light;
    logic [1:0] proto;
    logic [16:0] log_period;
    logic log_reject;
    logic [15:0] dil;
    logic comp;
  } ascr_regs_t;

  // Registered state and its next value
  ascr_regs_t r, nxt;
  logic [15:0] status_word;
  logic [31:0] status_chars;
  logic [ASCR_WORD_LEN*8-1:0] word;
  logic [ASCR_ID_LEN*8-1:0] id_field;
  ascr_cmd_t cmd;
  logic id_ok;
  logic is_term;

  // Character at a buffer position, first received first
  function automatic logic [7:0] ascr_char_at(input logic [LINE_LEN*8-1:0] buf_v, input int pos);
    ascr_char_at = buf_v[(LINE_LEN-1-pos)*8 +: 8];
  endfunction : ascr_char_at

  // One-byte answer: ACK when the request can be served, NAK when not
  function automatic logic [7:0] ascr_ack_byte(input logic ok);
    if (ok) begin
      ascr_ack_byte = ASCR_CH_ACK;
    end else begin
      ascr_ack_byte = ASCR_CH_NAK;
    end
  endfunction : ascr_ack_byte

  // Command word to command code; anything unknown decodes to none
  function automatic ascr_cmd_t ascr_decode_word(input logic [ASCR_WORD_LEN*8-1:0] w);
    if (w == ASCR_WORD_QUERY) begin
      ascr_decode_word = ASCR_CMD_CONC;
    end else if (w == ASCR_WORD_SPAN) begin
      ascr_decode_word = ASCR_CMD_SPAN;
    end else if (w == ASCR_WORD_ZERO) begin
      ascr_decode_word = ASCR_CMD_ZERO;
    end else if (w == ASCR_WORD_ABORT) begin
      ascr_decode_word = ASCR_CMD_ABORT;
    end else if (w == ASCR_WORD_RESET) begin
      ascr_decode_word = ASCR_CMD_RESET;
    end else begin
      ascr_decode_word = ASCR_CMD_NONE;
    end
  endfunction : ascr_decode_word

  // Status word assembly
  always_comb begin
    status_word = 16'h0000;
    status_word[15:ASCR_SW_FAULT_LSB] = cond_i.faults;
    status_word[ASCR_SW_OOS] = cond_i.out_of_service;
    status_word[ASCR_SW_ZERO] = (r.mode == ASCR_MODE_ZERO);
    status_word[ASCR_SW_SPAN] = (r.mode == ASCR_MODE_SPAN);
    status_word[ASCR_SW_UNUSED] = 1'b0;
    status_word[ASCR_SW_PPM] = cond_i.units_ppm;
    status_word[ASCR_SW_RSVD] = 1'b0;
  end

  ascr_hex_word ascr_hex_word_i (
    .word_i(status_word),
    .chars_o(status_chars)
  );

  // Command word, comma and identifier decode
  always_comb begin
    word = r.line[LINE_LEN*8-1 -: ASCR_WORD_LEN*8];
    id_field = r.line[(LINE_LEN-ASCR_WORD_LEN-1)*8-1 -: ASCR_ID_LEN*8];
    cmd = ASCR_CMD_NONE;
    // Only WORD,ID with nothing more is a candidate command
    if (r.len == 7'(ASCR_WORD_LEN + 1 + ASCR_ID_LEN) && !r.overflow &&
        ascr_char_at(r.line, ASCR_WORD_LEN) == ASCR_CH_COMMA) begin
      cmd = ascr_decode_word(word);
    end
    id_ok = (id_field == serial_id_i) ||
            (id_field == {ASCR_CH_QMARK, ASCR_CH_QMARK, ASCR_CH_QMARK});
    is_term = (rx_i.data == ASCR_CH_CR) || (rx_i.data == ASCR_CH_LF);
  end

  // Next-state logic
  always_comb begin
    nxt = r;
    nxt.reboot = 1'b0;
    // Parameter ports
    nxt.light = light_i;
    nxt.proto = proto_sel_i;
    nxt.log_reject = 1'b0;
    // Out-of-range period keeps the old value
    if (log_wr_i) begin
      if (log_period_i >= ASCR_LOG_MIN && log_period_i <= ASCR_LOG_MAX) begin
        nxt.log_period = log_period_i;
      end else begin
        nxt.log_reject = 1'b1;
      end
    end
    if (dil_wr_i) begin
      nxt.dil = dil_ratio_i;
    end
    if (comp_wr_i) begin
      nxt.comp = comp_sel_i;
    end
    // Receive, parse once, then send the reply byte by byte
    case (r.st)
      ASCR_ST_RX: begin
        if (rx_i.valid) begin
          if (is_term) begin
            nxt.st = ASCR_ST_PARSE;
          end else if (r.len < 7'(LINE_LEN)) begin
            nxt.line[(LINE_LEN-1-int'(r.len))*8 +: 8] = rx_i.data;
            nxt.len = r.len + 7'h01;
          end else begin
            // Too long: marked bad, still waits for the terminator
            nxt.overflow = 1'b1;
          end
        end
      end
      ASCR_ST_PARSE: begin
        nxt.st = ASCR_ST_RX;
        nxt.ridx = 5'h00;
        nxt.reply = '0;
        // Silent unless word, ID and protocol all fit
        if (cmd != ASCR_CMD_NONE && id_ok && proto_sel_i == ASCR_PROTO_COMMA) begin
          nxt.st = ASCR_ST_SEND;
          case (cmd)
            ASCR_CMD_CONC: begin
              nxt.reply = {gas_text_i, ASCR_CH_SPACE, status_chars, ASCR_CH_CR, ASCR_CH_LF};
              nxt.rlen = 5'(ASCR_REPLY_LEN);
            end
            ASCR_CMD_SPAN: begin
              nxt.rlen = 5'h01;
              nxt.reply[ASCR_REPLY_LEN*8-1 -: 8] = ascr_ack_byte(cal_allowed_i);
              if (cal_allowed_i) begin
                nxt.mode = ASCR_MODE_SPAN;
              end
            end
            ASCR_CMD_ZERO: begin
              nxt.rlen = 5'h01;
              nxt.reply[ASCR_REPLY_LEN*8-1 -: 8] = ascr_ack_byte(cal_allowed_i);
              if (cal_allowed_i) begin
                nxt.mode = ASCR_MODE_ZERO;
              end
            end
            ASCR_CMD_ABORT: begin
              nxt.rlen = 5'h01;
              nxt.reply[ASCR_REPLY_LEN*8-1 -: 8] = ascr_ack_byte(cal_allowed_i);
              if (cal_allowed_i) begin
                nxt.mode = ASCR_MODE_MEASURE;
              end
            end
            ASCR_CMD_RESET: begin
              nxt.rlen = 5'h01;
              nxt.reply[ASCR_REPLY_LEN*8-1 -: 8] = ASCR_CH_ACK;
              nxt.reboot_pend = 1'b1;
            end
            default: begin
              // Unreachable: only decoded commands get here
              nxt.st = ASCR_ST_RX;
            end
          endcase
        end
        // Buffer cleared for the next line
        nxt.line = '0;
        nxt.len = 7'h00;
        nxt.overflow = 1'b0;
      end
      ASCR_ST_SEND: begin
        // A byte stands until the host takes it
        if (!r.tx.valid || tx_ready_i) begin
          if (r.ridx < r.rlen) begin
            nxt.tx.valid = 1'b1;
            nxt.tx.data = r.reply[(ASCR_REPLY_LEN-1-int'(r.ridx))*8 +: 8];
            nxt.ridx = r.ridx + 5'h01;
          end else begin
            nxt.tx.valid = 1'b0;
            nxt.st = ASCR_ST_RX;
            // Reboot only once the ACK has left
            if (r.reboot_pend) begin
              nxt.reboot = 1'b1;
              nxt.reboot_pend = 1'b0;
              nxt.mode = ASCR_MODE_MEASURE;
            end
          end
        end
      end
      default: begin
        nxt.st = ASCR_ST_RX;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.st <= ASCR_ST_RX;
      r.mode <= ASCR_MODE_MEASURE;
      // Parameter outputs start at their defaults
      r.light <= ASCR_LIGHT_GREEN;
      r.proto <= ASCR_PROTO_COMMA;
      r.log_period <= ASCR_LOG_RESET;
      r.dil <= ASCR_DIL_RESET;
      r.comp <= ASCR_COMP_OLD;
    end else begin
      r <= nxt;
    end
  end

  // Outputs straight from flip-flops
  assign tx_o = r.tx;
  assign mode_o = r.mode;
  assign reboot_o = r.reboot;
  assign light_o = r.light;
  assign proto_o = r.proto;
  assign log_period_o = r.log_period;
  assign log_reject_o = r.log_reject;
  assign dil_ratio_o = r.dil;
  assign comp_sel_o = r.comp;
endmodule : ascr_responder

/* File: inc/ascr_pkg.sv */
/*
  Shared constants and carriers of the ASCII serial command responder.
  Assumes byte-wide receive and transmit streams synchronous to clk_i.
*/
package ascr_pkg;
  // Character codes
  localparam logic [7:0] ASCR_CH_CR = 8'h0d;
  localparam logic [7:0] ASCR_CH_LF = 8'h0a;
  localparam logic [7:0] ASCR_CH_COMMA = 8'h2c;
  localparam logic [7:0] ASCR_CH_QMARK = 8'h3f;
  localparam logic [7:0] ASCR_CH_SPACE = 8'h20;
  localparam logic [7:0] ASCR_CH_ACK = 8'h06;
  localparam logic [7:0] ASCR_CH_NAK = 8'h15;
  localparam logic [7:0] ASCR_CH_ZERO = 8'h30;
  localparam logic [7:0] ASCR_CH_A = 8'h41;
  // Line buffer and reply sizes
  localparam int ASCR_LINE_LEN = 16;
  localparam int ASCR_ID_LEN = 3;
  localparam int ASCR_GAS_LEN = 12;
  localparam int ASCR_REPLY_LEN = 19;
  // Command word length and the comma position
  localparam int ASCR_WORD_LEN = 5;
  // Command words as received, first character in the top byte
  localparam logic [ASCR_WORD_LEN*8-1:0] ASCR_WORD_QUERY = 40'h44434f4e43;
  localparam logic [ASCR_WORD_LEN*8-1:0] ASCR_WORD_SPAN = 40'h445350414e;
  localparam logic [ASCR_WORD_LEN*8-1:0] ASCR_WORD_ZERO = 40'h445a45524f;
  localparam logic [ASCR_WORD_LEN*8-1:0] ASCR_WORD_ABORT = 40'h41424f5254;
  localparam logic [ASCR_WORD_LEN*8-1:0] ASCR_WORD_RESET = 40'h5245534554;
  // Status word field positions
  localparam int ASCR_SW_FAULT_LSB = 6;
  localparam int ASCR_SW_OOS = 5;
  localparam int ASCR_SW_ZERO = 4;
  localparam int ASCR_SW_SPAN = 3;
  localparam int ASCR_SW_UNUSED = 2;
  localparam int ASCR_SW_PPM = 1;
  localparam int ASCR_SW_RSVD = 0;
  // Status light codes
  localparam logic [1:0] ASCR_LIGHT_GREEN = 2'h0;
  localparam logic [1:0] ASCR_LIGHT_AMBER = 2'h1;
  localparam logic [1:0] ASCR_LIGHT_OFF = 2'h2;
  localparam logic [1:0] ASCR_LIGHT_RED = 2'h3;
  // Network protocol codes
  localparam logic [1:0] ASCR_PROTO_COMMA = 2'h0;
  localparam logic [1:0] ASCR_PROTO_FRAMED = 2'h1;
  localparam logic [1:0] ASCR_PROTO_ADV = 2'h2;
  localparam logic [1:0] ASCR_PROTO_MODBUS = 2'h3;
  // Logging period limits, seconds
  localparam logic [16:0] ASCR_LOG_MIN = 17'h00001;
  localparam logic [16:0] ASCR_LOG_MAX = 17'h15180;
  localparam logic [16:0] ASCR_LOG_RESET = 17'h0003c;
  // Dilution ratio in 8.8 fixed point, 1.0 default
  localparam logic [15:0] ASCR_DIL_RESET = 16'h0100;
  // Compensation method codes
  localparam logic ASCR_COMP_NEW = 1'b0;
  localparam logic ASCR_COMP_OLD = 1'b1;
  // Recognised commands
  typedef enum logic [2:0] {
    ASCR_CMD_NONE = 3'b000,
    ASCR_CMD_CONC = 3'b001,
    ASCR_CMD_SPAN = 3'b010,
    ASCR_CMD_ZERO = 3'b011,
    ASCR_CMD_ABORT = 3'b100,
    ASCR_CMD_RESET = 3'b101
  } ascr_cmd_t;
  // Calibration modes
  typedef enum logic [1:0] {
    ASCR_MODE_MEASURE = 2'b00,
    ASCR_MODE_ZERO = 2'b01,
    ASCR_MODE_SPAN = 2'b10
  } ascr_mode_t;
  // Instrument condition inputs
  typedef struct packed {
    logic [9:0] faults;
    logic out_of_service;
    logic units_ppm;
  } ascr_cond_t;
  // One byte on a stream
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ascr_byte_t;
endpackage : ascr_pkg

/* File: logic/ascr_hex_word.sv */
/*
  Turns a 16-bit status word into four ASCII hex digits, MSB first.
  Assumes a purely combinational use inside the responder.
*/
`timescale 1ns/1ps
module ascr_hex_word
  import ascr_pkg::*;
(
  input wire logic [15:0] word_i,
  output logic [31:0] chars_o
);
  // Digit to upper-case hex character
  function automatic logic [7:0] ascr_hex_char(input logic [3:0] nib);
    if (nib < 4'ha) begin
      ascr_hex_char = ASCR_CH_ZERO + {4'h0, nib};
    end else begin
      ascr_hex_char = ASCR_CH_A + {4'h0, nib - 4'ha};
    end
  endfunction : ascr_hex_char

  // Four digits, most significant first
  always_comb begin
    chars_o = {ascr_hex_char(word_i[15:12]), ascr_hex_char(word_i[11:8]),
               ascr_hex_char(word_i[7:4]), ascr_hex_char(word_i[3:0])};
  end
endmodule : ascr_hex_word

/* File: testbench/ascr_responder_monitor.sv */
/*
  Port-level checker of the command responder.
  Assumes it is bound to ascr_responder and sees one clock domain.
*/
`timescale 1ns/1ps
module ascr_responder_monitor
  import ascr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tx_ready_i,
  input wire logic [1:0] light_i,
  input wire logic [1:0] proto_sel_i,
  input wire logic log_wr_i,
  input wire logic [16:0] log_period_i,
  input wire logic dil_wr_i,
  input wire logic [15:0] dil_ratio_i,
  input wire ascr_byte_t tx_o,
  input wire ascr_mode_t mode_o,
  input wire logic reboot_o,
  input wire logic [1:0] light_o,
  input wire logic [1:0] proto_o,
  input wire logic log_reject_o,
  input wire logic [15:0] dil_ratio_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Reply bytes stand until taken
  property p_tx_hold; tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o.data); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed before ready");
  // Entering span is acknowledged
  property p_span_ack; mode_o == ASCR_MODE_SPAN && $past(mode_o) != ASCR_MODE_SPAN |-> ##[0:2] tx_o.valid && tx_o.data == ASCR_CH_ACK; endproperty
  a_span_ack: assert property (p_span_ack) else $error("span entered without ack");
  // Entering zero is acknowledged
  property p_zero_ack; mode_o == ASCR_MODE_ZERO && $past(mode_o) != ASCR_MODE_ZERO |-> ##[0:2] tx_o.valid && tx_o.data == ASCR_CH_ACK; endproperty
  a_zero_ack: assert property (p_zero_ack) else $error("zero entered without ack");
  // Reboot request is a single pulse
  property p_reboot; reboot_o |=> !reboot_o; endproperty
  a_reboot: assert property (p_reboot) else $error("reboot pulse too long");
  // Light code follows its input
  property p_light; !$past(reset_i) |-> light_o == $past(light_i); endproperty
  a_light: assert property (p_light) else $error("light code wrong");
  // Protocol code follows its input
  property p_proto; !$past(reset_i) |-> proto_o == $past(proto_sel_i); endproperty
  a_proto: assert property (p_proto) else $error("protocol code wrong");
  // Logging period range check
  property p_log; log_wr_i |=> log_reject_o == ($past(log_period_i) < ASCR_LOG_MIN || $past(log_period_i) > ASCR_LOG_MAX); endproperty
  a_log: assert property (p_log) else $error("logging period range wrong");
  // Dilution ratio takes written value
  property p_dil; dil_wr_i |=> dil_ratio_o == $past(dil_ratio_i); endproperty
  a_dil: assert property (p_dil) else $error("dilution ratio not updated");
endmodule : ascr_responder_monitor

bind ascr_responder ascr_responder_monitor ascr_responder_monitor_i (.clk_i, .reset_i, .tx_ready_i, .light_i,
  .proto_sel_i, .log_wr_i, .log_period_i, .dil_wr_i, .dil_ratio_i, .tx_o, .mode_o, .reboot_o, .light_o, .proto_o,
  .log_reject_o, .dil_ratio_o);

/* File: testbench/ascr_host_model.sv */
/*
  Host on the serial line: sends command lines, collects reply bytes.
  Assumes byte streams synchronous to clk_i; slow_i stalls the ready line.
*/
`timescale 1ns/1ps
module ascr_host_model
  import ascr_pkg::*;
(
  input wire logic clk_i,
  input wire ascr_byte_t tx_i,
  input wire logic slow_i,
  output ascr_byte_t rx_o,
  output logic tx_ready_o
);
  logic [7:0] got[$];
  initial begin
    rx_o = '0;
    tx_ready_o = 1'b1;
  end
  // Ready always high, or every other cycle when slow
  always @(posedge clk_i) begin
    tx_ready_o <= #1 slow_i ? ~tx_ready_o : 1'b1;
    if (tx_i.valid === 1'b1 && tx_ready_o) got.push_back(tx_i.data);
  end
  // Ten-character line, one byte per pulse; data scrambled between bytes
  task automatic send(input logic [79:0] line);
    for (int i = 9; i >= 0; i--) begin
      @(posedge clk_i);
      #1 rx_o = '{valid: 1'b1, data: line[8*i+:8]};
      @(posedge clk_i);
      #1 rx_o = '{valid: 1'b0, data: ~line[8*i+:8]};
    end
  endtask : send
endmodule : ascr_host_model

/* File: testbench/ascr_responder_tb.sv */
/*
  Self-checking bench of the command responder.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module ascr_responder_tb
  import ascr_pkg::*;
;
  localparam logic [39:0] w_query = 40'h44434f4e43;
  localparam logic [39:0] w_span = 40'h445350414e;
  localparam logic [39:0] w_zero = 40'h445a45524f;
  localparam logic [39:0] w_abort = 40'h41424f5254;
  localparam logic [39:0] w_reset = 40'h5245534554;
  localparam logic [23:0] any_id = 24'h3f3f3f;
  logic clk_i, reset_i, cal_allowed_i, log_wr_i, dil_wr_i, comp_wr_i, comp_sel_i, slow, tx_ready_i;
  logic reboot_o, log_reject_o, comp_sel_o;
  logic [1:0] light_i, proto_sel_i, light_o, proto_o;
  logic [16:0] log_period_i, log_period_o;
  logic [15:0] dil_ratio_i, dil_ratio_o;
  logic [23:0] serial_id_i;
  logic [95:0] gas_text_i;
  logic [39:0] w_cal[3] = '{w_span, w_zero, w_abort};
  logic [16:0] lv[4] = '{17'h00000, 17'h00001, 17'h15180, 17'h15181};
  ascr_cond_t cond_i;
  ascr_byte_t rx_i, tx_o;
  ascr_mode_t mode_o;
  int miscompares, n_tests, reboots;
  ascr_responder ascr_responder_i (.clk_i, .reset_i, .rx_i, .tx_ready_i, .serial_id_i, .gas_text_i, .cond_i,
    .cal_allowed_i, .light_i, .proto_sel_i, .log_wr_i, .log_period_i, .dil_wr_i, .dil_ratio_i, .comp_wr_i,
    .comp_sel_i, .tx_o, .mode_o, .reboot_o, .light_o, .proto_o, .log_period_o, .log_reject_o, .dil_ratio_o,
    .comp_sel_o);
  ascr_host_model ascr_host_model_i (.clk_i, .tx_i(tx_o), .slow_i(slow), .rx_o(rx_i), .tx_ready_o(tx_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (reboot_o === 1'b1) reboots++;
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // Sends one line, waits for n reply bytes and checks nothing more follows
  task automatic cmd(input logic [39:0] w, input logic [23:0] id, input logic [7:0] term, input int n);
    int k;
    ascr_host_model_i.got.delete();
    ascr_host_model_i.send({w, ASCR_CH_COMMA, id, term});
    for (k = 0; k < 400 && ascr_host_model_i.got.size() < n; k++) @(posedge clk_i);
    if (k == 400) begin
      $display("BAD %0t reply timeout", $time);
      miscompares++;
      print_verdict();
    end else begin
      repeat (40) @(posedge clk_i);
      #1 chk(17'(ascr_host_model_i.got.size()), 17'(n));
    end
  endtask : cmd
  task automatic ack(input logic [7:0] b, input ascr_mode_t m);
    chk(17'(ascr_host_model_i.got[0]), 17'(b));
    chk(17'(mode_o), 17'(m));
  endtask : ack
  function automatic logic [31:0] hex4(input logic [15:0] v);
    for (int i = 0; i < 4; i++) hex4[8*i+:8] = v[4*i+:4] < 4'ha ? 8'h30 + v[4*i+:4] : 8'h37 + v[4*i+:4];
  endfunction : hex4
  // Query with wildcard id and compare all reply bytes
  task automatic conc(input ascr_mode_t m);
    logic [151:0] e;
    e = {gas_text_i, ASCR_CH_SPACE, hex4({cond_i.faults, cond_i.out_of_service, m == ASCR_MODE_ZERO,
      m == ASCR_MODE_SPAN, 1'b0, cond_i.units_ppm, 1'b0}), ASCR_CH_CR, ASCR_CH_LF};
    cmd(w_query, any_id, ASCR_CH_CR, 19);
    for (int i = 0; i < 19; i++) chk(17'(ascr_host_model_i.got[i]), 17'(e[8*(18-i)+:8]));
  endtask : conc
  // Main sequence
  initial begin
    {reset_i, cal_allowed_i, log_wr_i, dil_wr_i, comp_wr_i, comp_sel_i, slow} = 7'h40;
    {light_i, proto_sel_i, log_period_i, dil_ratio_i} = '0;
    serial_id_i = 24'h303937;
    gas_text_i = "      12.345";
    cond_i = '{faults: 10'h2a5, out_of_service: 1'b1, units_ppm: 1'b1};
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    chk(log_period_o, ASCR_LOG_RESET);
    chk(17'(dil_ratio_o), 17'(ASCR_DIL_RESET));
    chk(17'(comp_sel_o), 17'(ASCR_COMP_OLD));
    conc(ASCR_MODE_MEASURE);
    cal_allowed_i = 1'b1;
    cmd(w_span, serial_id_i, ASCR_CH_LF, 1);
    ack(ASCR_CH_ACK, ASCR_MODE_SPAN);
    slow = 1'b1;
    conc(ASCR_MODE_SPAN);
    slow = 1'b0;
    cmd(w_zero, serial_id_i, ASCR_CH_CR, 1);
    ack(ASCR_CH_ACK, ASCR_MODE_ZERO);
    cond_i = '{faults: 10'h15a, out_of_service: 1'b0, units_ppm: 1'b0};
    conc(ASCR_MODE_ZERO);
    cmd(w_abort, any_id, ASCR_CH_LF, 1);
    ack(ASCR_CH_ACK, ASCR_MODE_MEASURE);
    cal_allowed_i = 1'b0;
    for (int i = 0; i < 3; i++) begin
      cmd(w_cal[i], any_id, ASCR_CH_CR, 1);
      ack(ASCR_CH_NAK, ASCR_MODE_MEASURE);
    end
    cal_allowed_i = 1'b1;
    cmd(w_span, 24'h303938, ASCR_CH_CR, 0);
    cmd(40'h445350414f, serial_id_i, ASCR_CH_CR, 0);
    proto_sel_i = ASCR_PROTO_ADV;
    cmd(w_query, any_id, ASCR_CH_CR, 0);
    for (int i = 0; i < 4; i++) begin
      light_i = 2'(i);
      proto_sel_i = 2'(3 - i);
      repeat (2) @(posedge clk_i);
      #1 chk(17'(light_o), 17'(i));
      chk(17'(proto_o), 17'(3 - i));
    end
    for (int i = 0; i < 4; i++) begin
      log_period_i = lv[i];
      log_wr_i = 1'b1;
      @(posedge clk_i);
      #1 chk(17'(log_reject_o), 17'(i == 0 || i == 3));
      chk(log_period_o, i == 0 ? ASCR_LOG_RESET : lv[i == 3 ? 2 : i]);
    end
    log_wr_i = 1'b0;
    {dil_ratio_i, dil_wr_i, comp_wr_i, comp_sel_i} = {16'h0280, 3'h6};
    @(posedge clk_i);
    #1 {dil_wr_i, comp_wr_i} = 2'h0;
    chk(17'(dil_ratio_o), 17'h00280);
    chk(17'(comp_sel_o), 17'(ASCR_COMP_NEW));
    cmd(w_span, any_id, ASCR_CH_CR, 1);
    cmd(w_reset, serial_id_i, ASCR_CH_LF, 1);
    ack(ASCR_CH_ACK, ASCR_MODE_MEASURE);
    chk(17'(reboots), 17'h00001);
    print_verdict();
  end
endmodule : ascr_responder_tb
